//--- hw/startup_cfg_defs.svh
`ifndef STARTUP_CFG_DEFS_SVH
`define STARTUP_CFG_DEFS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define RESET_AND_CLOCK_CONFIG_CONTROL_ADDR 16'hf1e0
`define RESET_AND_CLOCK_CONFIG_CONTROL_WR_MASK 16'he103
`define RESET_AND_CLOCK_CONFIG_CONTROL_HI_RESET 8'h00
`define CLOCK_GEN_MODE_FIELD_MSB 15
`define CLOCK_GEN_MODE_FIELD_LSB 13
`define COPY_MSB 15
`define COPY_LSB 9
`define SUE_BIT 8
`define RESET_LENGTH_FIELD_MSB 1
`define RESET_LENGTH_FIELD_LSB 0

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define LATCHED_SC_DEFAULT 16'h202d
`define CLOCK_GEN_MODE_FIELD_PLL_X2_5 3'h0
`define CLOCK_GEN_MODE_FIELD_PRESCALE 3'h1
`define CLOCK_GEN_MODE_FIELD_DIRECT 3'h3
`define CLOCK_GEN_MODE_FIELD_PLL_X4 3'h7
`define RESET_LENGTH_FIELD_STD 2'h0
`define RESET_LENGTH_FIELD_EXT 2'h1
`define USER_START_ADDR 24'h000000
`define BOOT_BYTE_COUNT 6'h20

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RST_LEN_STD_TCL 1024
`define RST_LEN_EXT_TCL 2048
`define TCL_PER_CLK 2
`define RST_STD_CYCLES (`RST_LEN_STD_TCL / `TCL_PER_CLK)
`define RST_EXT_CYCLES (`RST_LEN_EXT_TCL / `TCL_PER_CLK)
`define RST_CNT_W 11

`endif

//--- hw/startup_cfg_pkg.sv
package startup_cfg_pkg;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_EXTERNAL,
        MODE_STD_START,
        MODE_ALT_START,
        MODE_BOOT_LOADER,
        MODE_ALT_BOOT
    } startup_mode_t;

    typedef enum logic [1:0] {
        SRC_SDD,
        SRC_PRESCALE,
        SRC_DIRECT,
        SRC_PLL
    } clk_src_t;

    typedef enum logic [1:0] {
        SEQ_HOLD,
        SEQ_COUNT,
        SEQ_DONE
    } seq_state_t;

    // Configuration pins sampled during reset
    typedef struct packed {
        logic ea;
        logic rd;
        logic ale;
        logic wr;
    } strap_t;

    // Long- or short-address memory access to the register
    typedef struct packed {
        logic [15:0] addr;
        logic short_space;
        logic rd;
        logic wr;
        logic [15:0] wdata;
    } mem_req_t;

endpackage

//--- hw/strap_sync.sv
`timescale 1ns/10ps

// Two-stage synchroniser for pin levels
module strap_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] stage1;

    // No reset: straps must keep being sampled while reset is high
    always_ff @(posedge sys_clk_i)
    begin
        stage1 <= async_i;
        sync_o <= stage1;
    end
endmodule

//--- hw/clk_src_ctrl.sv
`timescale 1ns/10ps
`include "startup_cfg_defs.svh"

// Selects the clock source from the latched mode and the loop lock
module clk_src_ctrl (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic sdd_mode_i,
    input wire logic [2:0] clock_gen_mode_field_i,
    input wire logic pll_lock_i,
    output startup_cfg_pkg::clk_src_t clk_src_o
);
    import startup_cfg_pkg::*;

    logic uses_pll;

    // Every mode other than prescaler and direct drive runs on the loop
    assign uses_pll = (clock_gen_mode_field_i != `CLOCK_GEN_MODE_FIELD_PRESCALE) && (clock_gen_mode_field_i != `CLOCK_GEN_MODE_FIELD_DIRECT);

    // Source choice; mode changes only happen while the divider drives
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            clk_src_o <= SRC_PRESCALE;
        else if (sdd_mode_i)
            clk_src_o <= SRC_SDD;                         // [RQ14]
        else if (clock_gen_mode_field_i == `CLOCK_GEN_MODE_FIELD_PRESCALE)
            clk_src_o <= SRC_PRESCALE;                    // [RQ21]
        else if (clock_gen_mode_field_i == `CLOCK_GEN_MODE_FIELD_DIRECT)
            clk_src_o <= SRC_DIRECT;                      // [RQ21]
        else if (!pll_lock_i)
            clk_src_o <= SRC_DIRECT;                      // [RQ15]
        else
            clk_src_o <= SRC_PLL;                         // [RQ15]
    end

    a_pll_wait: assert property ( // [RQ15]
        @(posedge sys_clk_i) disable iff (reset_i)
        (!sdd_mode_i && uses_pll && !pll_lock_i) |=> (clk_src_o == SRC_DIRECT))
        else $error("Multiplied clock chosen before lock");

    a_sdd_pass: assert property ( // [RQ14]
        @(posedge sys_clk_i) disable iff (reset_i)
        sdd_mode_i |=> (clk_src_o == SRC_SDD))
        else $error("Divider mode not driving the clock");
endmodule

//--- hw/startup_cfg.sv
`timescale 1ns/10ps
`include "startup_cfg_defs.svh"

// Overview of operation
// (RQ1) Latch startup mode from read strobe, latch enable
// (RQ2) Read strobe picks start/boot, latch enable variant
// (RQ3) Read high, latch low: standard start, address zero
// (RQ4) Both low: bootstrap loader, 32 bytes serial
// (RQ5) Straps must not choose undefined options
// (RQ6) Write strobe high: general port stays disabled
// (RQ7) Write strobe low: general port enabled, inputs
// (RQ8) Every other reset keeps general port disabled
// (RQ9) Mode and port decodes independent of each other
// (RQ10) System control writable only before end-of-init
// (RQ11) Latched mode reloads on divider entry if enabled
// (RQ12) Copy control bits 15..9 to latched config
// (RQ13) Software: write, enter divider, return basic
// (RQ14) Divider pass keeps clock switching glitch free
// (RQ15) Direct drive until loop lock, then multiply
// (RQ16) After end-of-init, write only right after unlock
// (RQ17) Control register only at long address F1E0
// (RQ18) Length code 00 1024, 01 2048 half periods
// (RQ19) New length affects only the next sequence
// (RQ20) Update enable bit gates clock config changes
// (RQ21) Three-bit mode field selects clock source
// (RQ22) Reserved control bits ignore writes, read zero
module startup_cfg (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic por_i,
    input wire startup_cfg_pkg::strap_t strap_pins_i,
    input wire logic pll_lock_i,
    input wire startup_cfg_pkg::mem_req_t mem_req_i,
    input wire logic end_of_init_instruction_i,
    input wire logic unlock_i,
    input wire logic sdd_mode_i,
    output logic [15:0] mem_rdata_o,
    output logic mem_ack_o,
    output logic in_reset_o,
    output logic cfg_ready_o,
    output startup_cfg_pkg::startup_mode_t startup_mode_o,
    output logic boot_loader_o,
    output logic [5:0] boot_bytes_o,
    output logic [23:0] first_fetch_addr_o,
    output logic port20_en_o,
    output logic sysctl_wr_ok_o,
    output logic [15:0] latched_cfg_o,
    output startup_cfg_pkg::clk_src_t clk_src_o
);
    import startup_cfg_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    strap_t strap_sync_v;
    strap_t strap_cap;
    logic lock_sync;
    seq_state_t seq_state;
    logic [`RST_CNT_W-1:0] seq_cnt;
    logic [15:0] reset_and_clock_config_control;
    logic [1:0] reset_length_field;
    logic end_of_init_instruction_done;
    logic unlock_armed;
    logic sdd_q;
    logic hit;
    logic wr_ok;
    logic sdd_entry;
    logic seq_end;
    logic [`RST_CNT_W:0] run_cycles;
    logic [`RST_CNT_W:0] run_expect;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    strap_sync #(.W($bits(strap_t))) u_strap_sync (
        .sys_clk_i(sys_clk_i),
        .async_i(strap_pins_i),
        .sync_o(strap_sync_v)
    );

    strap_sync #(.W(1)) u_lock_sync (
        .sys_clk_i(sys_clk_i),
        .async_i(pll_lock_i),
        .sync_o(lock_sync)
    );

    // ------------------------------------------------------------
    // Reset sequence
    // ------------------------------------------------------------

    // Sequence length is taken from the code held before a plain reset, the standard code after power-on
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            seq_state <= SEQ_HOLD;
            seq_cnt <= '0;
        end
        else
        begin
            case (seq_state)
                SEQ_HOLD:
                begin
                    seq_state <= SEQ_COUNT;
                    if (reset_length_field == `RESET_LENGTH_FIELD_EXT)
                        seq_cnt <= `RST_CNT_W'(`RST_EXT_CYCLES - 1); // [RQ18] [RQ19]
                    else
                        seq_cnt <= `RST_CNT_W'(`RST_STD_CYCLES - 1); // [RQ18] [RQ19]
                end
                SEQ_COUNT:
                begin
                    if (seq_cnt == '0)
                        seq_state <= SEQ_DONE;
                    else
                        seq_cnt <= seq_cnt - `RST_CNT_W'(1);
                end
                SEQ_DONE:
                    seq_state <= SEQ_DONE;
                default:
                    seq_state <= SEQ_HOLD;
            endcase
        end
    end

    assign seq_end = (seq_state == SEQ_COUNT) && (seq_cnt == '0);

    // Reset indication to the rest of the chip
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            in_reset_o <= 1'b1;
        else if (seq_end)
            in_reset_o <= 1'b0;
    end

    // Straps follow the pins until the sequence ends, then freeze
    always_ff @(posedge sys_clk_i)
    begin
        if (seq_state != SEQ_DONE)
            strap_cap <= strap_sync_v;                    // [RQ1]
    end

    // ------------------------------------------------------------
    // Startup decode
    // ------------------------------------------------------------

    // Startup mode from read strobe and latch enable
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            startup_mode_o <= MODE_EXTERNAL;
            boot_loader_o <= 1'b0;
            boot_bytes_o <= 6'h00;
            first_fetch_addr_o <= `USER_START_ADDR;
        end
        else if (seq_end)
        begin
            boot_loader_o <= strap_cap.ea && !strap_cap.rd && !strap_cap.ale; // [RQ4]
            boot_bytes_o <= 6'h00;
            if (!strap_cap.ea)
                startup_mode_o <= MODE_EXTERNAL;
            else
            begin
                case ({strap_cap.rd, strap_cap.ale})      // [RQ2]
                    2'b10: startup_mode_o <= MODE_STD_START; // [RQ3]
                    2'b11: startup_mode_o <= MODE_ALT_START; // [RQ5]
                    2'b00:
                    begin
                        startup_mode_o <= MODE_BOOT_LOADER;  // [RQ4]
                        boot_bytes_o <= `BOOT_BYTE_COUNT;    // [RQ4]
                    end
                    2'b01: startup_mode_o <= MODE_ALT_BOOT;  // [RQ5]
                    default: startup_mode_o <= MODE_EXTERNAL;
                endcase
            end
            first_fetch_addr_o <= `USER_START_ADDR;      // [RQ3]
        end
    end

    // General port enable, decoded on its own from the write strobe
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            port20_en_o <= 1'b0;                          // [RQ8]
        else if (seq_end)
            port20_en_o <= strap_cap.ea && !strap_cap.wr; // [RQ6] [RQ7] [RQ9]
    end

    // Configuration valid once the sequence has ended
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            cfg_ready_o <= 1'b0;
        else if (seq_end)
            cfg_ready_o <= 1'b1;
    end

    // ------------------------------------------------------------
    // Protection
    // ------------------------------------------------------------

    // End-of-init seen; system control locked from then on
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            end_of_init_instruction_done <= 1'b0;
            sysctl_wr_ok_o <= 1'b1;
        end
        else if (end_of_init_instruction_i)
        begin
            end_of_init_instruction_done <= 1'b1;
            sysctl_wr_ok_o <= 1'b0;                       // [RQ10]
        end
    end

    // Unlock opens exactly the next bus access; a new unlock wins
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            unlock_armed <= 1'b0;
        else if (unlock_i)
            unlock_armed <= 1'b1;
        else if (mem_req_i.rd || mem_req_i.wr)
            unlock_armed <= 1'b0;                         // [RQ16]
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    assign hit = (mem_req_i.addr == `RESET_AND_CLOCK_CONFIG_CONTROL_ADDR) && !mem_req_i.short_space; // [RQ17]
    assign wr_ok = hit && mem_req_i.wr && (!end_of_init_instruction_done || unlock_armed); // [RQ10] [RQ16]

    // Mode and update-enable bits; cleared by every reset
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            reset_and_clock_config_control <= {`RESET_AND_CLOCK_CONFIG_CONTROL_HI_RESET, 8'h00};
        else if (wr_ok)
            reset_and_clock_config_control <= mem_req_i.wdata & `RESET_AND_CLOCK_CONFIG_CONTROL_WR_MASK & 16'hfffc; // [RQ22]
    end

    // Length code survives a plain reset, cleared at power-on only
    always_ff @(posedge sys_clk_i)
    begin
        if (por_i)
            reset_length_field <= `RESET_LENGTH_FIELD_STD;
        else if (wr_ok && !reset_i)
            reset_length_field <= mem_req_i.wdata[`RESET_LENGTH_FIELD_MSB:`RESET_LENGTH_FIELD_LSB]; // [RQ19]
    end

    // Read answer, one cycle after the request
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            mem_rdata_o <= 16'h0000;
            mem_ack_o <= 1'b0;
        end
        else
        begin
            mem_ack_o <= hit && (mem_req_i.rd || mem_req_i.wr);
            if (hit && mem_req_i.rd)
                mem_rdata_o <= reset_and_clock_config_control | {14'h0000, reset_length_field}; // [RQ22]
            else
                mem_rdata_o <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Latched configuration
    // ------------------------------------------------------------

    // Divider entry detection
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            sdd_q <= 1'b0;
        else
            sdd_q <= sdd_mode_i;
    end

    assign sdd_entry = sdd_mode_i && !sdd_q;

    // Copy of the mode bits happens only on entry with update enabled
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            latched_cfg_o <= `LATCHED_SC_DEFAULT;         // [RQ11]
        else if (sdd_entry && reset_and_clock_config_control[`SUE_BIT])         // [RQ11] [RQ20]
            latched_cfg_o[`COPY_MSB:`COPY_LSB] <= reset_and_clock_config_control[`COPY_MSB:`COPY_LSB]; // [RQ12]
    end

    // ------------------------------------------------------------
    // Clock source
    // ------------------------------------------------------------
    clk_src_ctrl u_clk_src (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .sdd_mode_i(sdd_mode_i),
        .clock_gen_mode_field_i(latched_cfg_o[`CLOCK_GEN_MODE_FIELD_MSB:`CLOCK_GEN_MODE_FIELD_LSB]), // [RQ21]
        .pll_lock_i(lock_sync),
        .clk_src_o(clk_src_o)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    // Cycles spent counting, checked against the chosen length
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            run_cycles <= '0;
            run_expect <= '0;
        end
        else if (seq_state == SEQ_HOLD)
        begin
            run_cycles <= '0;
            run_expect <= (reset_length_field == `RESET_LENGTH_FIELD_EXT) ? (`RST_CNT_W+1)'(`RST_EXT_CYCLES) :
                (`RST_CNT_W+1)'(`RST_STD_CYCLES);
        end
        else if (seq_state == SEQ_COUNT)
            run_cycles <= run_cycles + (`RST_CNT_W+1)'(1);
    end

    sequence s_sdd_entry;
        !sdd_mode_i ##1 sdd_mode_i;
    endsequence

    sequence s_unlocked_write;
        unlock_i ##1 (hit && mem_req_i.wr);
    endsequence

    a_std_start_mode: assert property ( // [RQ3]
        seq_end && strap_cap.ea && strap_cap.rd && !strap_cap.ale
        |=> (startup_mode_o == MODE_STD_START) && !boot_loader_o)
        else $error("Standard start not selected");

    a_boot_mode: assert property ( // [RQ4]
        seq_end && strap_cap.ea && !strap_cap.rd && !strap_cap.ale
        |=> boot_loader_o && (boot_bytes_o == 6'h20))
        else $error("Bootstrap loader not selected");

    a_port_enable: assert property ( // [RQ7]
        $rose(cfg_ready_o) |-> (port20_en_o == ($past(strap_cap.ea) && !$past(strap_cap.wr)))
        ) else $error("General port enable wrong");

    a_port_disabled: assert property ( // [RQ8]
        !cfg_ready_o |-> !port20_en_o)
        else $error("General port enabled during reset");

    a_sysctl_lock: assert property ( // [RQ10]
        end_of_init_instruction_i |=> !sysctl_wr_ok_o [*8])
        else $error("System control writable after end-of-init");

    a_locked_write: assert property ( // [RQ16]
        end_of_init_instruction_done && !unlock_armed && hit && mem_req_i.wr |=> $stable(reset_and_clock_config_control))
        else $error("Protected register written without unlock");

    a_unlock_write: assert property ( // [RQ16]
        s_unlocked_write |=> (reset_and_clock_config_control == ($past(mem_req_i.wdata) & 16'he100)))
        else $error("Unlocked write not accepted");

    a_short_ignored: assert property ( // [RQ17]
        mem_req_i.wr && mem_req_i.short_space |=> $stable(reset_and_clock_config_control) && $stable(reset_length_field))
        else $error("Short address reached the control register");

    a_sue_copy: assert property ( // [RQ12]
        s_sdd_entry ##0 reset_and_clock_config_control[8] |=> (latched_cfg_o[15:9] == $past(reset_and_clock_config_control[15:9])))
        else $error("Mode bits not copied on divider entry");

    a_sue_block: assert property ( // [RQ20]
        s_sdd_entry ##0 !reset_and_clock_config_control[8] |=> $stable(latched_cfg_o))
        else $error("Latched config changed with update disabled");

    a_reset_length: assert property ( // [RQ18]
        seq_end |=> (run_cycles == run_expect) && !in_reset_o)
        else $error("Reset sequence length wrong");
endmodule

//--- verification/strap_partner.sv
`timescale 1ns/10ps

// Strap circuitry on the configuration pins, and bus strobes once reset is over
module strap_partner (
    input wire logic sys_clk_i,
    input wire logic in_reset_i,
    input wire logic ea_i,
    input wire logic rd_i,
    input wire logic wr_i,
    output startup_cfg_pkg::strap_t strap_o
);
    import startup_cfg_pkg::*;

    logic [2:0] toggle;

    // After the sequence the strobe pins carry bus traffic: rd changes each cycle, ale every 2 cycles, wr every 4
    always_ff @(posedge sys_clk_i)
    begin
        if (in_reset_i)
            toggle <= 3'h0;
        else
            toggle <= toggle + 3'h1;
    end

    // Strapping keeps the latch enable low, so no undefined mode is chosen
    always_comb
    begin
        strap_o.ea = ea_i;
        strap_o.rd = in_reset_i ? rd_i : toggle[0];
        strap_o.ale = in_reset_i ? 1'b0 : toggle[1];
        strap_o.wr = in_reset_i ? wr_i : toggle[2];
    end
endmodule

//--- verification/startup_cfg_tb.sv
`timescale 1ns/10ps
`include "startup_cfg_defs.svh"

module startup_cfg_tb;
    import startup_cfg_pkg::*;

    // ----------------------------------------------------------------
    // Stimulus, outputs and model state
    // ----------------------------------------------------------------
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic por_i = 1'b1;
    logic pll_lock_i = 1'b0;
    logic end_of_init_instruction_i = 1'b0;
    logic unlock_i = 1'b0;
    logic sdd_mode_i = 1'b0;
    logic strap_ea = 1'b1;
    logic strap_rd = 1'b1;
    logic strap_wr = 1'b1;
    mem_req_t mem_req_i = '0;
    strap_t strap_pins;
    logic [15:0] mem_rdata_o;
    logic mem_ack_o;
    logic in_reset_o;
    logic cfg_ready_o;
    startup_mode_t startup_mode_o;
    logic boot_loader_o;
    logic [5:0] boot_bytes_o;
    logic [23:0] first_fetch_addr_o;
    logic port20_en_o;
    logic sysctl_wr_ok_o;
    logic [15:0] latched_cfg_o;
    clk_src_t clk_src_o;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int seed;
    int m_reg = 0;
    int m_lat = `LATCHED_SC_DEFAULT;
    int m_end_of_init_instruction = 0;
    logic [2:0] codes[$] = '{3'h7, 3'h3, 3'h0, 3'h1};

    always #10 sys_clk_i = ~sys_clk_i;

    strap_partner i_strap (.sys_clk_i(sys_clk_i), .in_reset_i(in_reset_o), .ea_i(strap_ea),
        .rd_i(strap_rd), .wr_i(strap_wr), .strap_o(strap_pins));

    startup_cfg i_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .por_i(por_i),
        .strap_pins_i(strap_pins), .pll_lock_i(pll_lock_i), .mem_req_i(mem_req_i),
        .end_of_init_instruction_i(end_of_init_instruction_i), .unlock_i(unlock_i), .sdd_mode_i(sdd_mode_i),
        .mem_rdata_o(mem_rdata_o), .mem_ack_o(mem_ack_o), .in_reset_o(in_reset_o),
        .cfg_ready_o(cfg_ready_o), .startup_mode_o(startup_mode_o),
        .boot_loader_o(boot_loader_o), .boot_bytes_o(boot_bytes_o),
        .first_fetch_addr_o(first_fetch_addr_o), .port20_en_o(port20_en_o),
        .sysctl_wr_ok_o(sysctl_wr_ok_o), .latched_cfg_o(latched_cfg_o),
        .clk_src_o(clk_src_o));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One access, optionally preceded by the unlock pulse in the cycle before
    task automatic bus(input logic rd_en, input logic [15:0] addr, input logic sh,
                       input logic [15:0] wdata, input logic unl);
        logic hit;
        hit = (addr == `RESET_AND_CLOCK_CONFIG_CONTROL_ADDR) && !sh;
        @(posedge sys_clk_i);
        #1;
        unlock_i = unl;
        @(posedge sys_clk_i);
        #1;
        unlock_i = 1'b0;
        mem_req_i = '{addr, sh, rd_en, !rd_en, wdata};
        @(posedge sys_clk_i);
        #1;
        mem_req_i = '0;
        chk("ack", hit, mem_ack_o);
        if (rd_en)
            chk("rdata", hit ? m_reg[15:0] : 16'h0, mem_rdata_o);
        else if (hit && (m_end_of_init_instruction == 0 || unl))
            m_reg = wdata & `RESET_AND_CLOCK_CONFIG_CONTROL_WR_MASK;
    endtask

    // Reset with given straps; mid >= 0 writes the register while the sequence runs
    task automatic do_reset(input logic por, input logic e, input logic r, input logic w,
                            input int mid);
        int start;
        int exp_len;
        startup_mode_t em;
        strap_ea = e;
        strap_rd = r;
        strap_wr = w;
        @(posedge sys_clk_i);
        #1;
        reset_i = 1'b1;
        por_i = por;
        repeat (10) @(posedge sys_clk_i);
        #1;
        reset_i = 1'b0;
        por_i = 1'b0;
        start = cycles;
        m_reg = por ? 0 : (m_reg & 3);
        m_lat = `LATCHED_SC_DEFAULT;
        m_end_of_init_instruction = 0;
        exp_len = (m_reg == 1) ? `RST_EXT_CYCLES : `RST_STD_CYCLES;
        if (mid >= 0)
            bus(1'b0, `RESET_AND_CLOCK_CONFIG_CONTROL_ADDR, 1'b0, mid[15:0], 1'b0);
        while (in_reset_o === 1'b1 && cycles - start < 3000)
        begin
            @(posedge sys_clk_i);
            #1;
        end
        chk("reset length ok", 1, (cycles - start >= exp_len) && (cycles - start <= exp_len + 3));
        repeat (8) @(posedge sys_clk_i);
        #1;
        em = !e ? MODE_EXTERNAL : (r ? MODE_STD_START : MODE_BOOT_LOADER);
        chk("mode", em, startup_mode_o);
        chk("boot", e && !r, boot_loader_o);
        chk("boot bytes", (e && !r) ? `BOOT_BYTE_COUNT : 6'h0, boot_bytes_o);
        chk("fetch", `USER_START_ADDR, first_fetch_addr_o);
        chk("port20", e && !w, port20_en_o);
        chk("ready", 1, cfg_ready_o);
        chk("latched", m_lat, latched_cfg_o);
        chk("sysctl ok", 1, sysctl_wr_ok_o);
        chk("src", SRC_PRESCALE, clk_src_o);
        bus(1'b1, `RESET_AND_CLOCK_CONFIG_CONTROL_ADDR, 1'b0, 16'h0, 1'b0);
    endtask

    function automatic clk_src_t exp_src(input logic [2:0] code, input logic lock);
        if (code == `CLOCK_GEN_MODE_FIELD_PRESCALE)
            return SRC_PRESCALE;
        if (code == `CLOCK_GEN_MODE_FIELD_DIRECT || !lock)
            return SRC_DIRECT;
        return SRC_PLL;
    endfunction

    // Write mode, pass through the divider, return and wait for lock
    task automatic sdd_pass(input logic [2:0] code, input logic software_update_enable_bit);
        logic [15:0] noise;
        noise = $urandom & 16'h1efc;
        bus(1'b0, `RESET_AND_CLOCK_CONFIG_CONTROL_ADDR, 1'b0, {code, 4'h0, software_update_enable_bit, 8'h00} | noise, 1'b0);
        pll_lock_i = 1'b0;
        sdd_mode_i = 1'b1;
        repeat (3) @(posedge sys_clk_i);
        #1;
        if (software_update_enable_bit)
            m_lat = (m_lat & 'h01ff) | (m_reg & 'hfe00);
        chk("src in divider", SRC_SDD, clk_src_o);
        chk("latched", m_lat, latched_cfg_o);
        sdd_mode_i = 1'b0;
        repeat (6) @(posedge sys_clk_i);
        #1;
        chk("src before lock", exp_src(m_lat[15:13], 1'b0), clk_src_o);
        pll_lock_i = 1'b1;
        repeat (6) @(posedge sys_clk_i);
        #1;
        chk("src after lock", exp_src(m_lat[15:13], 1'b1), clk_src_o);
    endtask

    // ----------------------------------------------------------------
    // Timeout and main sequence
    // ----------------------------------------------------------------
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            $display("ERROR timeout expected done seen running");
            test_done();
        end
    end

    initial
    begin
        seed = $urandom(9597);
        do_reset(1'b1, 1'b1, 1'b1, 1'b1, -1);
        for (int i = 0; i < 8; i++)
            do_reset(1'b0, i[2], i[1], i[0], -1);
        $display("test straps done");
        bus(1'b0, `RESET_AND_CLOCK_CONFIG_CONTROL_ADDR, 1'b0, 16'($urandom), 1'b0);
        bus(1'b1, `RESET_AND_CLOCK_CONFIG_CONTROL_ADDR, 1'b0, 16'h0, 1'b0);
        bus(1'b0, `RESET_AND_CLOCK_CONFIG_CONTROL_ADDR, 1'b1, 16'hffff, 1'b0);
        bus(1'b0, 16'hf1e2, 1'b0, 16'hffff, 1'b0);
        bus(1'b1, 16'hf0e0, 1'b0, 16'h0, 1'b0);
        bus(1'b1, `RESET_AND_CLOCK_CONFIG_CONTROL_ADDR, 1'b0, 16'h0, 1'b0);
        $display("test register map done");
        foreach (codes[k])
        begin
            sdd_pass(codes[k], 1'b0);
            sdd_pass(codes[k], 1'b1);
        end
        $display("test clock update done");
        @(posedge sys_clk_i);
        #1;
        end_of_init_instruction_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        end_of_init_instruction_i = 1'b0;
        m_end_of_init_instruction = 1;
        @(posedge sys_clk_i);
        #1;
        chk("sysctl ok", 0, sysctl_wr_ok_o);
        bus(1'b0, `RESET_AND_CLOCK_CONFIG_CONTROL_ADDR, 1'b0, 16'($urandom), 1'b0);
        bus(1'b1, `RESET_AND_CLOCK_CONFIG_CONTROL_ADDR, 1'b0, 16'h0, 1'b0);
        bus(1'b0, `RESET_AND_CLOCK_CONFIG_CONTROL_ADDR, 1'b0, 16'($urandom), 1'b1);
        bus(1'b1, `RESET_AND_CLOCK_CONFIG_CONTROL_ADDR, 1'b0, 16'h0, 1'b1);
        bus(1'b0, `RESET_AND_CLOCK_CONFIG_CONTROL_ADDR, 1'b0, 16'($urandom), 1'b0);
        bus(1'b1, `RESET_AND_CLOCK_CONFIG_CONTROL_ADDR, 1'b0, 16'h0, 1'b0);
        $display("test protection done");
        bus(1'b0, `RESET_AND_CLOCK_CONFIG_CONTROL_ADDR, 1'b0, 16'h0001, 1'b1);
        do_reset(1'b0, 1'b1, 1'b1, 1'b0, 0);
        do_reset(1'b0, 1'b1, 1'b0, 1'b1, -1);
        bus(1'b0, `RESET_AND_CLOCK_CONFIG_CONTROL_ADDR, 1'b0, 16'h0001, 1'b0);
        do_reset(1'b1, 1'b1, 1'b1, 1'b1, -1);
        $display("test reset length done");
        test_done();
    end
endmodule
